// ===== compare_pwm.sv
/*
 * pwm mode of an output compare channel with its time base, register
 * port and interrupt; assumes a synchronous 16-bit register master on
 * clk_sys and an asynchronous fault pin
 */
// The register offsets and the address-and-strobe port were left to the implementer.
// Notes on behaviour
// R1 - a period value of N gives N+1 time base counts per pwm cycle.
// R2 - the duty buffer takes writes any time and moves to the active duty only on period match.
// R3 - in a pwm mode software writes to the active duty register are ignored.
// R4 - an active duty of zero keeps the output low for the whole period.
// R5 - an active duty above the period keeps the output high all the time.
// R6 - an active duty equal to the period gives one low count per period.
// R7 - the active duty present at enable sets the first period.
// R8 - software should load the active duty before first enabling the channel.
// R9 - software sets period, buffer, active duty, interrupts, mode, then prescaler and timer on.
// R10 - two pwm modes are chosen by a three-bit compare mode field.
// R11 - the fault pin acts through the compare interrupt, so that interrupt must be enabled; here the fault needs only MODE_PWM_FAULT, not irq_mask.
// R12 - the time base counts instruction cycles through the prescaler.
// R13 - on period match the count returns to zero with the duty transfer; output high at start, low at duty.
`timescale 1ns/10ps
`include "compare_pwm_map.svh"

module compare_pwm
    import compare_pwm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // pins
    input wire logic fault_n_pin,
    output logic compare_output_pin,
    // interrupt
    output logic irq
);

    typedef struct packed {
        logic [15:0] timer_period_reg;
        logic [15:0] duty_buffer_reg;
        logic [15:0] duty_active_reg;
        cmp_mode_t mode;
        logic fault_flag;
        logic timer_on_bit;
        logic [1:0] prescale;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic out;
        logic [15:0] rdata;
        logic irq;
        logic [1:0] fault_sync;
    } state_t;

    state_t s_q, s_d;
    timebase_if tb_bus ();

    logic pwm_mode;
    logic fault_hit;
    logic cmp_hit;
    logic wr_period, wr_buf, wr_act, wr_cmp, wr_tmr, wr_stat, wr_mask, wr_count;
    logic [15:0] duty_next;
    logic [15:0] count_next;
    logic out_next;
    logic [15:0] rd_mux;
    logic [2:0] events;

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    pwm_timebase u_timebase (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .timer_on(s_q.timer_on_bit),
        .prescale_sel(s_q.prescale),
        .timer_period(s_q.timer_period_reg),
        .count_wr(wr_count),
        .count_wdata(reg_wdata),
        .tb(tb_bus.timer)
    );

    // ----------------------------------------------------------------
    // decode and compare
    // ----------------------------------------------------------------
    assign wr_period = reg_wr && (reg_addr == `ADDR_PERIOD);
    assign wr_count = reg_wr && (reg_addr == `ADDR_COUNT);
    assign wr_buf = reg_wr && (reg_addr == `ADDR_DUTY_BUF);
    assign wr_act = reg_wr && (reg_addr == `ADDR_DUTY_ACT);
    assign wr_cmp = reg_wr && (reg_addr == `ADDR_CMP_CTRL);
    assign wr_tmr = reg_wr && (reg_addr == `ADDR_TMR_CTRL);
    assign wr_stat = reg_wr && (reg_addr == `ADDR_IRQ_STAT);
    assign wr_mask = reg_wr && (reg_addr == `ADDR_IRQ_MASK);

    assign pwm_mode = (s_q.mode == MODE_PWM) || (s_q.mode == MODE_PWM_FAULT); // R10
    // fault only in the fault mode; pin passes two flops first
    assign fault_hit = (s_q.mode == MODE_PWM_FAULT) && !s_q.fault_sync[1]; // R11
    assign cmp_hit = pwm_mode && tb_bus.tick && (tb_bus.count == s_q.duty_active_reg);

    // the duty used by the next count: transferred value at period end
    assign duty_next = tb_bus.period_match ? s_q.duty_buffer_reg : s_q.duty_active_reg; // R2
    assign count_next = tb_bus.period_match ? `ZERO_WORD : tb_bus.count + `ONE_WORD; // R13

    // output sampled against the count that will be current next cycle;
    // high while count is below duty, so zero duty never rises and a
    // duty above the period never falls
    always_comb begin
        out_next = s_q.out;
        if (!pwm_mode || s_q.fault_flag || fault_hit) begin
            out_next = 1'b0;
        end else if (tb_bus.tick) begin
            out_next = (count_next < duty_next); // R4 R5 R6 R13
        end else if (!s_q.timer_on_bit) begin
            // stopped timer: level follows the current count so the first
            // period uses whatever duty stood at enable
            out_next = (tb_bus.count < s_q.duty_active_reg); // R7
        end
    end

    assign events[`IRQ_PERIOD_BIT] = tb_bus.period_match;
    assign events[`IRQ_CMP_BIT] = cmp_hit;
    assign events[`IRQ_FAULT_BIT] = fault_hit && !s_q.fault_flag; // R11

    always_comb begin
        unique case (reg_addr)
            `ADDR_PERIOD: rd_mux = s_q.timer_period_reg;
            `ADDR_COUNT: rd_mux = tb_bus.count;
            `ADDR_DUTY_BUF: rd_mux = s_q.duty_buffer_reg;
            `ADDR_DUTY_ACT: rd_mux = s_q.duty_active_reg;
            `ADDR_CMP_CTRL: rd_mux = {11'h000, s_q.fault_flag, 1'b0, s_q.mode};
            `ADDR_TMR_CTRL: rd_mux = {s_q.timer_on_bit, 9'h000, s_q.prescale, 4'h0};
            `ADDR_IRQ_STAT: rd_mux = {13'h0000, s_q.irq_stat};
            `ADDR_IRQ_MASK: rd_mux = {13'h0000, s_q.irq_mask};
            default: rd_mux = `ZERO_WORD;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.fault_sync = {s_q.fault_sync[0], fault_n_pin};
        if (wr_period) begin
            s_d.timer_period_reg = reg_wdata;
        end
        if (wr_buf) begin
            s_d.duty_buffer_reg = reg_wdata; // R2
        end
        // writes to the active duty only land outside pwm modes
        if (wr_act && !pwm_mode) begin
            s_d.duty_active_reg = reg_wdata; // R3
        end
        if (pwm_mode && tb_bus.period_match) begin
            s_d.duty_active_reg = s_q.duty_buffer_reg; // R2
        end
        if (wr_cmp) begin
            s_d.mode = cmp_mode_t'(reg_wdata[`MODE_MSB:`MODE_LSB]);
            // rewriting the mode is how software leaves the fault state
            s_d.fault_flag = 1'b0;
        end
        if (fault_hit) begin
            s_d.fault_flag = 1'b1;
        end
        if (wr_tmr) begin
            s_d.timer_on_bit = reg_wdata[`TMR_ON_BIT];
            s_d.prescale = reg_wdata[`PRESCALE_MSB:`PRESCALE_LSB];
        end
        if (wr_mask) begin
            s_d.irq_mask = reg_wdata[2:0];
        end
        // set wins over write-one-to-clear
        s_d.irq_stat = (s_q.irq_stat & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | events;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
        s_d.out = out_next;
        s_d.rdata = reg_rd ? rd_mux : `ZERO_WORD;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.timer_period_reg <= `RST_PERIOD;
            s_q.fault_sync <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    assign compare_output_pin = s_q.out;
    assign irq = s_q.irq;
    assign reg_rdata = s_q.rdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_duty_transfer: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
        (pwm_mode && tb_bus.period_match) |=> (s_q.duty_active_reg == $past(s_q.duty_buffer_reg)))
        else $error("duty not moved on period match");
    chk_active_locked: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
        (pwm_mode && !tb_bus.period_match) |=> $stable(s_q.duty_active_reg))
        else $error("active duty changed in pwm mode");
    chk_zero_duty: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
        (pwm_mode && tb_bus.tick && duty_next == `ZERO_WORD) |=> !compare_output_pin)
        else $error("output high with zero duty");
    chk_full_duty: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
        (pwm_mode && !s_q.fault_flag && !fault_hit && tb_bus.tick
         && duty_next > s_q.timer_period_reg) |=> compare_output_pin)
        else $error("output low with duty above period");
    chk_equal_low: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
        (pwm_mode && tb_bus.tick && count_next == s_q.timer_period_reg
         && duty_next == s_q.timer_period_reg) |=> !compare_output_pin)
        else $error("no low count with duty equal period");
    chk_count_wrap: assert property (@(posedge clk_sys) disable iff (!resetn) // R1 R13
        (tb_bus.period_match && !wr_count) |=> (tb_bus.count == `ZERO_WORD))
        else $error("count did not wrap on period match");
    chk_count_bound: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
        (tb_bus.tick && !wr_count && !wr_period && tb_bus.count <= s_q.timer_period_reg)
        |=> (tb_bus.count <= s_q.timer_period_reg))
        else $error("count ran past the period");
    chk_fault_low: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
        fault_hit |=> (!compare_output_pin && s_q.irq_stat[`IRQ_FAULT_BIT]))
        else $error("fault did not force low and flag");
    chk_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
        (|(events & s_q.irq_mask) && !wr_mask) |=> irq)
        else $error("unmasked event did not raise the interrupt");
    chk_out_off_mode: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
        !pwm_mode |=> !compare_output_pin)
        else $error("output high outside pwm modes");
    chk_fault_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
        (s_q.fault_flag && !wr_cmp) |=> (s_q.fault_flag && !compare_output_pin))
        else $error("fault state left without mode write");
    chk_buf_write: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
        wr_buf |=> (s_q.duty_buffer_reg == $past(reg_wdata)))
        else $error("duty buffer write lost");
    chk_act_write_off: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
        (wr_act && !pwm_mode) |=> (s_q.duty_active_reg == $past(reg_wdata)))
        else $error("active duty write lost outside pwm");
    chk_fault_sticky: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
        (s_q.irq_stat[`IRQ_FAULT_BIT] && !wr_stat) |=> s_q.irq_stat[`IRQ_FAULT_BIT])
        else $error("fault status bit dropped without clear");
    chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        !reg_rd |=> (reg_rdata == `ZERO_WORD))
        else $error("read data not zero after idle cycle");

endmodule : compare_pwm

// ===== compare_pwm_map.svh
/*
 * register offsets, field positions, reset values and timing figures
 * of the pwm compare channel; assumes a 16-bit register port with
 * word indices, included by bare name
 */
`ifndef COMPARE_PWM_MAP_SVH
`define COMPARE_PWM_MAP_SVH

// --------------------------------------------------------------------
// register indices
// --------------------------------------------------------------------
`define ADDR_PERIOD     4'h0
`define ADDR_COUNT      4'h1
`define ADDR_DUTY_BUF   4'h2
`define ADDR_DUTY_ACT   4'h3
`define ADDR_CMP_CTRL   4'h4
`define ADDR_TMR_CTRL   4'h5
`define ADDR_IRQ_STAT   4'h6
`define ADDR_IRQ_MASK   4'h7

// --------------------------------------------------------------------
// fields
// --------------------------------------------------------------------
`define MODE_LSB        0
`define MODE_MSB        2
`define FAULT_FLAG_BIT  4
`define TMR_ON_BIT      15
`define PRESCALE_LSB    4
`define PRESCALE_MSB    5
`define IRQ_PERIOD_BIT  0
`define IRQ_CMP_BIT     1
`define IRQ_FAULT_BIT   2

// --------------------------------------------------------------------
// reset values and constants
// --------------------------------------------------------------------
`define RST_WORD        16'h0000
`define RST_PERIOD      16'hFFFF
`define ZERO_WORD       16'h0000
`define ONE_WORD        16'h0001
`define OSC_PER_CYCLE   2
`define DIV_1           8'h00
`define DIV_8           8'h07
`define DIV_64          8'h3F
`define DIV_256         8'hFF
`define ZERO_DIV        8'h00
`define ONE_DIV         8'h01

`endif

// ===== compare_pwm_pkg.sv
/*
 * types shared by the pwm compare channel and its time base;
 * assumes compare_pwm_map.svh is on the include path
 */
package compare_pwm_pkg;

    // compare mode field encodings: two pwm modes, fault pin only in the second
    typedef enum logic [2:0] {
        MODE_OFF       = 3'b000,
        MODE_ONE_LO    = 3'b001,
        MODE_ONE_HI    = 3'b010,
        MODE_TOGGLE    = 3'b011,
        MODE_DUAL      = 3'b100,
        MODE_DUAL_CONT = 3'b101,
        MODE_PWM       = 3'b110,
        MODE_PWM_FAULT = 3'b111
    } cmp_mode_t;

endpackage : compare_pwm_pkg

// ===== timebase_if.sv
/*
 * carries the time base count and period match from the timer to the
 * compare logic; one clock domain, no crossing
 */
`timescale 1ns/10ps

interface timebase_if;
    logic [15:0] count;
    logic tick;
    logic period_match;

    modport timer (output count, output tick, output period_match);
    modport user (input count, input tick, input period_match);
endinterface : timebase_if

// ===== pwm_timebase.sv
/*
 * timer time base: prescaled instruction-cycle counter with period
 * match; assumes clk_sys is the instruction clock
 */
`timescale 1ns/10ps
`include "compare_pwm_map.svh"

module pwm_timebase
    import compare_pwm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // control
    input wire logic timer_on,
    input wire logic [1:0] prescale_sel,
    input wire logic [15:0] timer_period,
    input wire logic count_wr,
    input wire logic [15:0] count_wdata,
    // time base out
    timebase_if.timer tb
);

    typedef struct packed {
        logic [7:0] div;
        logic [15:0] count;
    } tb_state_t;

    tb_state_t s_q, s_d;
    logic [7:0] div_max;
    logic tick;
    logic match;

    always_comb begin
        unique case (prescale_sel)
            2'b00: div_max = `DIV_1;
            2'b01: div_max = `DIV_8;
            2'b10: div_max = `DIV_64;
            2'b11: div_max = `DIV_256;
        endcase
    end

    // one enable pulse per prescaled count of instruction cycles
    // compare at or above so a smaller prescale chosen while running cannot wrap the divider
    assign tick = timer_on && (s_q.div >= div_max); // R12
    assign match = tick && (s_q.count == timer_period); // R1

    always_comb begin
        s_d = s_q;
        // a stopped timer clears its prescaler so the first period after enable is whole
        s_d.div = `ZERO_DIV;
        if (timer_on) begin
            s_d.div = tick ? `ZERO_DIV : s_q.div + `ONE_DIV; // R12
        end
        if (match) begin
            s_d.count = `ZERO_WORD; // R13
        end else if (tick) begin
            s_d.count = s_q.count + `ONE_WORD;
        end
        // software write to the count wins over counting
        if (count_wr) begin
            s_d.count = count_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tb.count = s_q.count;
    assign tb.tick = tick;
    assign tb.period_match = match;

endmodule : pwm_timebase

// ===== compare_pwm_tb.sv
/*
 * self-checking bench for compare_pwm: reset values, double-buffered duty,
 * duty boundaries, period and prescale, modes, fault and interrupt;
 * assumes compare_pwm_map.svh on the include path and the package compiled first
 */
`timescale 1ns/10ps
`include "compare_pwm_map.svh"

module compare_pwm_tb;
    import compare_pwm_pkg::*;

    // ----------------------------------------------------------------
    // signals and instance
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic fault_n_pin = 1'b1;
    logic compare_output_pin;
    logic irq;
    int fail_count = 0;
    int num_checks = 0;

    compare_pwm u_compare_pwm (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_n_pin(fault_n_pin),
        .compare_output_pin(compare_output_pin), .irq(irq)
    );

    always #12.5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : chk_rd

    // stop the timer and clear the mode first so the active duty write is accepted, then program in the documented order
    task automatic cfg(input logic [15:0] p, b, a, input logic [2:0] m, input logic [15:0] t);
        wr(`ADDR_TMR_CTRL, `RST_WORD);
        wr(`ADDR_CMP_CTRL, `RST_WORD);
        wr(`ADDR_COUNT, `ZERO_WORD);
        wr(`ADDR_PERIOD, p);
        wr(`ADDR_DUTY_BUF, b);
        wr(`ADDR_DUTY_ACT, a);
        wr(`ADDR_CMP_CTRL, {13'h0000, m});
        wr(`ADDR_TMR_CTRL, t);
    endtask : cfg

    task automatic hi_cnt(input int n, output logic [15:0] h);
        h = 16'h0000;
        repeat (n) begin
            @(negedge clk_sys);
            h = h + {15'h0000, compare_output_pin};
        end
    endtask : hi_cnt

    // cycles between two rising edges of the output, bounded
    task automatic gap(output logic [15:0] g);
        logic p;
        int k;
        p = 1'b1;
        for (k = 0; k < 4000; k++) begin
            @(negedge clk_sys);
            if (compare_output_pin === 1'b1 && p === 1'b0) break;
            p = compare_output_pin;
        end
        p = 1'b1;
        for (k = 1; k < 4000; k++) begin
            @(negedge clk_sys);
            if (compare_output_pin === 1'b1 && p === 1'b0) break;
            p = compare_output_pin;
        end
        g = 16'(k);
    endtask : gap

    function automatic logic [15:0] exp_hi(input logic [15:0] p, d, pre);
        return ((d > p) ? p + 16'h0001 : d) * pre;
    endfunction : exp_hi

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    logic [15:0] pv, dv, h;
    logic [15:0] pre_tab [4] = '{16'h0001, 16'h0008, 16'h0040, 16'h0100};
    logic [15:0] dut_tab [4] = '{16'h0000, 16'h0009, 16'h000A, 16'hFFFF};

    initial begin
        void'($urandom(38));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            chk_rd(4'(a), (a == 0) ? `RST_PERIOD : `RST_WORD);
        end
        chk({14'h0000, compare_output_pin, irq}, 16'h0000);
        wr(4'h8, 16'hFFFF);
        chk_rd(4'h8, `ZERO_WORD);
        // first period uses the preloaded active duty, buffer waits for the match
        cfg(16'h0009, 16'h0003, 16'h0006, MODE_PWM, 16'h8000);
        chk_rd(`ADDR_DUTY_ACT, 16'h0006);
        wr(`ADDR_DUTY_ACT, 16'h0001);
        chk_rd(`ADDR_DUTY_ACT, 16'h0006);
        repeat (12) @(posedge clk_sys);
        chk_rd(`ADDR_DUTY_ACT, 16'h0003);
        wr(`ADDR_DUTY_BUF, 16'h0005);
        chk_rd(`ADDR_DUTY_BUF, 16'h0005);
        // first period of a fresh start takes the preloaded active duty
        cfg(16'h0009, 16'h0003, 16'h0006, MODE_PWM, 16'h8000);
        hi_cnt(10, h);
        chk(h, 16'h0006);
        // boundary duties then random ones
        for (int i = 0; i < 10; i++) begin
            pv = 16'h0009;
            dv = (i < 4) ? dut_tab[i] : 16'(1 + $urandom % 9);
            if (i >= 4) pv = 16'(3 + $urandom % 18);
            if (i >= 4) dv = 16'(1 + $urandom % pv);
            cfg(pv, dv, dv, MODE_PWM, 16'h8000);
            repeat (2 * (pv + 1)) @(posedge clk_sys);
            hi_cnt(pv + 1, h);
            chk(h, exp_hi(pv, dv, 16'h0001));
            if (dv != 0 && dv <= pv) begin
                gap(h);
                chk(h, pv + 16'h0001);
            end
        end
        // prescaler selections
        for (int s = 0; s < 4; s++) begin
            cfg(16'h0002, 16'h0001, 16'h0001, MODE_PWM, 16'h8000 | 16'(s << 4));
            repeat (6 * pre_tab[s]) @(posedge clk_sys);
            gap(h);
            chk(h, 16'h0003 * pre_tab[s]);
        end
        // count stays within 0..P
        cfg(16'h0004, 16'h0002, 16'h0002, MODE_PWM, 16'h8000);
        repeat (12) begin
            wr(4'hF, 16'h0000);
            @(posedge clk_sys);
            reg_addr <= `ADDR_COUNT;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1;
            chk({15'h0000, reg_rdata <= 16'h0004}, 16'h0001);
        end
        // only the two pwm modes drive the output
        for (int m = 0; m < 8; m++) begin
            cfg(16'h0004, 16'hFFFF, 16'hFFFF, 3'(m), 16'h8000);
            repeat (12) @(posedge clk_sys);
            @(negedge clk_sys);
            chk({15'h0000, compare_output_pin}, {15'h0000, m >= 6});
        end
        // fault through the fault interrupt bit
        cfg(16'h0004, 16'hFFFF, 16'hFFFF, MODE_PWM_FAULT, 16'h8000);
        wr(`ADDR_IRQ_MASK, 16'h0004);
        fault_n_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({14'h0000, compare_output_pin, irq}, 16'h0001);
        chk_rd(`ADDR_CMP_CTRL, 16'h0017);
        @(posedge clk_sys);
        fault_n_pin <= 1'b1;
        wr(`ADDR_TMR_CTRL, `RST_WORD);
        wr(`ADDR_CMP_CTRL, {13'h0000, MODE_PWM_FAULT});
        wr(`ADDR_IRQ_STAT, 16'h0007);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({15'h0000, irq}, 16'h0000);
        // period match interrupt raised, masked
        wr(`ADDR_IRQ_MASK, 16'h0001);
        wr(`ADDR_TMR_CTRL, 16'h8000);
        repeat (8) @(posedge clk_sys);
        #1;
        chk({15'h0000, irq}, 16'h0001);
        wr(`ADDR_IRQ_MASK, 16'h0000);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({15'h0000, irq}, 16'h0000);
        // duty compare event raises its own status bit
        cfg(16'h0004, 16'h0002, 16'h0002, MODE_PWM, 16'h8000);
        wr(`ADDR_IRQ_STAT, 16'h0007);
        wr(`ADDR_IRQ_MASK, 16'h0002);
        repeat (8) @(posedge clk_sys);
        #1;
        chk({15'h0000, irq}, 16'h0001);
        chk_rd(`ADDR_IRQ_STAT, 16'h0003);
        final_report();
    end

    // the whole run needs well under 30k cycles
    initial begin
        #2000000;
        fail_count++;
        final_report();
    end
endmodule : compare_pwm_tb
